/* ess_host_model.sv */
/* host flash controller model: shifts frames msb first.
   assumes one caller at a time; clock idles low between frames. */
`timescale 1ns/1ns
`default_nettype none
module ess_host_model
    import ess_pkg::*;
#(
    parameter int unsigned HALF_NS = 40,
    parameter int unsigned PHASE_NS = 3,
    parameter int unsigned GAP_NS = 300,
    parameter int unsigned RESUME_TO_PAUSE_GAP_NS = 1000
)
(
    // command link
    output logic link_clk,
    output logic link_cs_n,
    output logic link_data_in
);
    initial
    begin
        link_clk = 1'b0;
        link_cs_n = 1'b1;
        link_data_in = 1'b1;
    end
    // sends top n bits of v; n off 8 or 32 breaks framing on purpose
    task automatic send(input logic [31:0] v, input int n);
        #PHASE_NS link_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            link_data_in = v[31 - i];
            #HALF_NS link_clk = 1'b1;
            #HALF_NS link_clk = 1'b0;
        end
        // released line shows the inverse, not a stale bit
        link_data_in = ~link_data_in;
        #HALF_NS link_cs_n = 1'b1;
        #GAP_NS;
        if (v[31:24] == OP_RESUME)
            #RESUME_TO_PAUSE_GAP_NS;
    endtask
endmodule
`default_nettype wire

/* ess_pkg.sv */
/*
 * shared constants for the erase / suspend sequencer: opcodes, frame
 * lengths, array geometry, protection encoding, timing and state codes.
 * assumes a 100 MHz system clock and a byte-wide single-line command link.
 */
`default_nettype none
package ess_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_BLOCK64 = 8'hD8;
    localparam logic [7:0] OP_BLOCK32 = 8'h52;
    localparam logic [7:0] OP_SECTOR = 8'h20;
    localparam logic [7:0] OP_CHIP_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;
    localparam logic [7:0] OP_PAUSE = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    // frame lengths in link clocks
    localparam logic [5:0] BITS_OPCODE = 6'h08;
    localparam logic [5:0] BITS_ADDR_CMD = 6'h20;
    localparam logic [5:0] BITS_SAT = 6'h3F;
    localparam logic [5:0] BITS_OP_LAST = 6'h07;
    // array geometry in bytes
    localparam logic [22:0] ARRAY_BYTES = 23'h400000;
    localparam logic [22:0] BLOCK64_BYTES = 23'h010000;
    localparam logic [22:0] BLOCK32_BYTES = 23'h008000;
    localparam logic [22:0] SECTOR_BYTES = 23'h001000;
    localparam logic [22:0] PAGE_BYTES = 23'h000100;
    // protection level codes
    localparam logic [2:0] PROT_NONE = 3'h0;
    localparam logic [2:0] PROT_ALL = 3'h7;
    localparam logic [2:0] PROT_SMALL_CAP = 3'h4;
    localparam logic [2:0] PROT_STEP = 3'h1;
    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned PAUSE_LATENCY_US = 20;
    localparam logic [11:0] PAUSE_LATENCY_CYC =
        12'(PAUSE_LATENCY_US * CLK_MHZ - 1);
    localparam int unsigned RESUME_BUSY_NS = 200;
    localparam int unsigned RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_NS;
    // operation kinds
    typedef enum logic [2:0] {
        K_SECTOR = 3'h0,
        K_HALF = 3'h1,
        K_BLOCK = 3'h2,
        K_CHIP = 3'h3,
        K_PROG = 3'h4,
        K_SECPROG = 3'h5
    } ess_kind_e;
    // operation states
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RUN = 5'b00010,
        ST_PAUSING = 5'b00100,
        ST_PAUSED = 5'b01000,
        ST_NESTED = 5'b10000
    } ess_state_e;
endpackage
`default_nettype wire

/* ess_sequencer.sv */
/*
 * erase / suspend sequencer: block, half block, sector and whole-array
 * erase, suspend and resume of sector, half block or block erase or non-secure page program, write-enable latch,
 * busy and paused flags. assumes a host driving cs_n, link clock and data
 * msb first in single-line mode; status reads and page data are served by
 * sibling logic that reads the flags here.
 */
`timescale 1ns/1ns
`default_nettype none
module ess_sequencer
    import ess_pkg::*;
#(
    parameter int unsigned LARGE_ERASE_TIME_US = 2000,
    parameter int unsigned HALF_ERASE_TIME_US = 1500,
    parameter int unsigned SECTOR_ERASE_TIME_US = 1000,
    parameter int unsigned CHIP_ERASE_TIME_US = 8000,
    parameter int unsigned PROG_TIME_US = 500
)
(
    // system
    input wire logic clk_sys,
    input wire logic reset,
    // command link
    input wire logic link_clk,
    input wire logic link_cs_n,
    input wire logic link_data_in,
    // protection settings
    input wire logic top_bottom_select,
    input wire logic small_unit_protect,
    input wire logic protect_level_2,
    input wire logic protect_level_1,
    input wire logic protect_level_0,
    // page program requests from sibling logic
    input wire logic prog_start,
    input wire logic [23:0] prog_addr,
    input wire logic prog_secure,
    // status
    output logic busy_r,
    output logic paused_op_flag_r,
    output logic write_enable_latch_r,
    output logic page_prog_block_r,
    // array operation
    output logic array_op_active_r,
    output ess_pkg::ess_kind_e array_op_kind_r,
    output logic [23:0] array_op_addr_r
);
    import ess_pkg::*;

    localparam logic [31:0] LARGE_CYC = 32'(LARGE_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] HALF_CYC = 32'(HALF_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] SECTOR_CYC = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] CHIP_CYC = 32'(CHIP_ERASE_TIME_US * CLK_MHZ);
    localparam logic [31:0] PROG_CYC = 32'(PROG_TIME_US * CLK_MHZ);

    function automatic logic [22:0] unit_bytes(ess_kind_e k);
        logic [22:0] s;
        s = PAGE_BYTES;
        case (k)
            K_SECTOR: s = SECTOR_BYTES;
            K_HALF: s = BLOCK32_BYTES;
            K_BLOCK: s = BLOCK64_BYTES;
            K_CHIP: s = ARRAY_BYTES;
            default: s = PAGE_BYTES;
        endcase
        return s;
    endfunction

    function automatic logic [31:0] run_cycles(ess_kind_e k);
        logic [31:0] c;
        c = PROG_CYC;
        case (k)
            K_SECTOR: c = SECTOR_CYC;
            K_HALF: c = HALF_CYC;
            K_BLOCK: c = LARGE_CYC;
            K_CHIP: c = CHIP_CYC;
            default: c = PROG_CYC;
        endcase
        return c;
    endfunction

    // aligned start of the unit that holds an address
    function automatic logic [22:0] unit_base(logic [23:0] a, ess_kind_e k);
        logic [22:0] lo;
        lo = {1'b0, a[21:0]};
        return lo & ~(unit_bytes(k) - 23'h000001);
    endfunction

    // protection map: one region at the top or bottom of the array
    function automatic logic prot_hit(logic [22:0] lo, logic [22:0] sz,
                                      logic tb, logic sm, logic [2:0] lv);
        logic [22:0] psz;
        logic [22:0] plo;
        psz = '0;
        if (lv == PROT_ALL)
            psz = ARRAY_BYTES;
        else if (!sm)
            psz = 23'(BLOCK64_BYTES << (lv - PROT_STEP));
        else if (lv >= PROT_SMALL_CAP)
            psz = BLOCK32_BYTES;
        else
            psz = 23'(SECTOR_BYTES << (lv - PROT_STEP));
        plo = tb ? '0 : 23'(ARRAY_BYTES - psz);
        return (lv != PROT_NONE) && (lo < 23'(plo + psz)) &&
               (plo < 23'(lo + sz));
    endfunction

    // link domain: shift in, count bits, mark frame with a toggle
    logic first_r;
    logic [5:0] bit_cnt_r;
    logic [31:0] shift_r;
    logic [7:0] opcode_r;
    logic frame_tog_r;

    // cs_n high rearms the frame; it only ever forces a constant
    always_ff @(posedge link_clk or posedge link_cs_n)
    begin
        if (link_cs_n)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    always_ff @(posedge link_clk)
    begin
        shift_r <= {shift_r[30:0], link_data_in};
        if (first_r)
            bit_cnt_r <= 6'h01;
        else if (bit_cnt_r != BITS_SAT)
            bit_cnt_r <= bit_cnt_r + 6'h01;
    end

    always_ff @(posedge link_clk)
    begin
        if (first_r)
            opcode_r <= {7'h00, link_data_in};
        else if (bit_cnt_r == BITS_OP_LAST)
            opcode_r <= {shift_r[6:0], link_data_in};
    end

    always_ff @(posedge link_clk or posedge reset)
    begin
        if (reset)
            frame_tog_r <= 1'b0;
        else if (first_r)
            frame_tog_r <= ~frame_tog_r;
    end

    // system domain: synchronise cs_n and the frame toggle
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_seen_r;

    always_ff @(posedge clk_sys)
    begin
        cs_s1_r <= link_cs_n;
        cs_s2_r <= cs_s1_r;
        cs_s3_r <= cs_s2_r;
        tog_s1_r <= frame_tog_r;
        tog_s2_r <= tog_s1_r;
    end

    // link registers are still once cs_n has risen and the clock stopped
    logic frame_end;
    assign frame_end = cs_s2_r && !cs_s3_r && (tog_s2_r != tog_seen_r);

    logic frm_valid_r;
    logic [5:0] frm_cnt_r;
    logic [7:0] frm_op_r;
    logic [23:0] frm_addr_r;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tog_seen_r <= 1'b0;
            frm_valid_r <= 1'b0;
            frm_cnt_r <= '0;
            frm_op_r <= '0;
            frm_addr_r <= '0;
        end
        else
        begin
            frm_valid_r <= frame_end;
            if (frame_end)
            begin
                tog_seen_r <= tog_s2_r;
                frm_cnt_r <= bit_cnt_r;
                frm_op_r <= opcode_r;
                frm_addr_r <= shift_r[23:0];
            end
        end
    end

    // command decode
    logic [2:0] prot_lv;
    logic is8;
    logic is32;
    logic cmd_wren;
    logic cmd_addr_erase;
    logic cmd_chip;
    logic cmd_pause;
    logic cmd_resume;
    ess_kind_e erase_kind;
    logic [22:0] erase_lo;
    logic erase_ok;
    logic chip_ok;
    logic prog_ok;
    logic nested_ok;

    assign prot_lv = {protect_level_2, protect_level_1, protect_level_0};
    assign is8 = frm_valid_r && (frm_cnt_r == BITS_OPCODE);
    assign is32 = frm_valid_r && (frm_cnt_r == BITS_ADDR_CMD);
    assign cmd_wren = is8 && (frm_op_r == OP_WREN);
    assign cmd_addr_erase = is32 && ((frm_op_r == OP_BLOCK64) ||
        (frm_op_r == OP_BLOCK32) || (frm_op_r == OP_SECTOR));
    assign cmd_chip = is8 && ((frm_op_r == OP_CHIP_A) ||
        (frm_op_r == OP_CHIP_B));
    assign cmd_pause = is8 && (frm_op_r == OP_PAUSE);
    assign cmd_resume = is8 && (frm_op_r == OP_RESUME);

    always_comb
    begin
        erase_kind = K_SECTOR;
        if (frm_op_r == OP_BLOCK64)
            erase_kind = K_BLOCK;
        else if (frm_op_r == OP_BLOCK32)
            erase_kind = K_HALF;
    end

    assign erase_lo = unit_base(frm_addr_r, erase_kind);

    ess_state_e state_r;
    ess_state_e state_nxt;
    ess_kind_e act_kind_r;
    logic [23:0] act_addr_r;
    logic [31:0] act_left_r;
    ess_kind_e sav_kind_r;
    logic [23:0] sav_addr_r;
    logic [31:0] sav_left_r;
    logic [11:0] lat_r;
    logic done;

    // any erase needs idle array: a pause state also blocks it
    assign erase_ok = cmd_addr_erase && write_enable_latch_r &&
        (state_r == ST_IDLE) &&
        !prot_hit(erase_lo, unit_bytes(erase_kind), top_bottom_select,
                  small_unit_protect, prot_lv);
    assign chip_ok = cmd_chip && write_enable_latch_r &&
        (state_r == ST_IDLE) &&
        !prot_hit('0, ARRAY_BYTES, top_bottom_select,
                  small_unit_protect, prot_lv);
    assign prog_ok = prog_start && (state_r == ST_IDLE);
    // program during an erase pause, never into the paused sector
    assign nested_ok = prog_start && !prog_secure &&
        (state_r == ST_PAUSED) && (sav_kind_r != K_PROG) &&
        (unit_base(prog_addr, K_SECTOR) !=
         unit_base(sav_addr_r, K_SECTOR));
    assign done = (act_left_r == 32'h00000001);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (erase_ok || chip_ok || prog_ok)
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                if (done)
                    state_nxt = ST_IDLE;
                else if (cmd_pause && (act_kind_r != K_CHIP) &&
                         (act_kind_r != K_SECPROG))
                    state_nxt = ST_PAUSING;
            end
            ST_PAUSING:
            begin
                if (lat_r == '0)
                    state_nxt = ST_PAUSED;
            end
            ST_PAUSED:
            begin
                if (cmd_resume)
                    state_nxt = ST_RUN;
                else if (nested_ok)
                    state_nxt = ST_NESTED;
            end
            ST_NESTED:
            begin
                if (done)
                    state_nxt = ST_PAUSED;
            end
        endcase
    end

    // reset stands for power-up: a pause never survives it
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            lat_r <= '0;
        else if (state_r == ST_RUN && state_nxt == ST_PAUSING)
            lat_r <= PAUSE_LATENCY_CYC;
        else if (lat_r != '0)
            lat_r <= lat_r - 12'h001;
    end

    // active operation: progress only counts while running
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            act_kind_r <= K_SECTOR;
            act_addr_r <= '0;
            act_left_r <= '0;
        end
        else if (state_r == ST_IDLE && (erase_ok || chip_ok))
        begin
            act_kind_r <= chip_ok ? K_CHIP : erase_kind;
            act_addr_r <= chip_ok ? '0 : frm_addr_r;
            act_left_r <= run_cycles(chip_ok ? K_CHIP : erase_kind);
        end
        else if (prog_ok || nested_ok)
        begin
            act_kind_r <= prog_secure ? K_SECPROG : K_PROG;
            act_addr_r <= prog_addr;
            act_left_r <= PROG_CYC;
        end
        else if (state_r == ST_PAUSED && cmd_resume)
        begin
            act_kind_r <= sav_kind_r;
            act_addr_r <= sav_addr_r;
            act_left_r <= sav_left_r;
        end
        else if ((state_r == ST_RUN || state_r == ST_NESTED) && !done &&
                 state_nxt != ST_PAUSING)
            act_left_r <= act_left_r - 32'h00000001;
    end

    // saved operation; cleared at power-up since the data may be lost
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sav_kind_r <= K_SECTOR;
            sav_addr_r <= '0;
            sav_left_r <= '0;
        end
        else if (state_r == ST_PAUSING && state_nxt == ST_PAUSED)
        begin
            sav_kind_r <= act_kind_r;
            sav_addr_r <= act_addr_r;
            sav_left_r <= act_left_r;
        end
    end

    // write-enable latch: completion clears, 06h sets
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            write_enable_latch_r <= 1'b0;
        else if ((state_r == ST_RUN || state_r == ST_NESTED) && done)
            write_enable_latch_r <= 1'b0;
        else if (cmd_wren)
            write_enable_latch_r <= 1'b1;
    end

    // status flags; busy covers running, pausing and a nested program, but drops once paused
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            busy_r <= 1'b0;
            paused_op_flag_r <= 1'b0;
            page_prog_block_r <= 1'b0;
        end
        else
        begin
            busy_r <= (state_nxt == ST_RUN) || (state_nxt == ST_PAUSING) ||
                (state_nxt == ST_NESTED);
            paused_op_flag_r <= (state_nxt == ST_PAUSING) ||
                (state_nxt == ST_PAUSED) ||
                (state_nxt == ST_NESTED);
            // for a paused page program, block follows the paused flag from the moment it rises
            page_prog_block_r <= (state_nxt == ST_PAUSING ||
                state_nxt == ST_PAUSED || state_nxt == ST_NESTED) &&
                ((state_r == ST_RUN || state_r == ST_PAUSING) ?
                 (act_kind_r == K_PROG) : (sav_kind_r == K_PROG));
        end
    end

    // array action follows the running operation; halts while paused
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            array_op_active_r <= 1'b0;
            array_op_kind_r <= K_SECTOR;
            array_op_addr_r <= '0;
        end
        else
        begin
            array_op_active_r <= (state_nxt == ST_RUN) ||
                (state_nxt == ST_NESTED);
            array_op_kind_r <= act_kind_r;
            array_op_addr_r <= act_addr_r;
        end
    end
endmodule
`default_nettype wire

/* ess_sequencer_assertions.sv */
/* checker for the erase / suspend sequencer flags.
   bound to ess_sequencer; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module ess_sequencer_assertions
    import ess_pkg::*;
(
    // clocks and reset
    input wire logic clk_sys,
    input wire logic reset,
    // protection
    input wire logic protect_level_2,
    input wire logic protect_level_1,
    input wire logic protect_level_0,
    // status
    input wire logic busy_r,
    input wire logic paused_op_flag_r,
    input wire logic write_enable_latch_r,
    input wire logic array_op_active_r,
    input wire ess_pkg::ess_kind_e array_op_kind_r
);
    logic [11:0] hold_r;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // pause wait is too long for a repetition, so count it; a nested
    // program keeps busy and the flag up too, but with the array active
    always_ff @(posedge clk_sys)
    begin
        if (reset || !(busy_r && paused_op_flag_r && !array_op_active_r))
            hold_r <= 12'h000;
        else
            hold_r <= hold_r + 12'h001;
    end
    property p_pause_lat;
        hold_r <= 12'h7D2;
    endproperty
    a_pause_lat: assert property (p_pause_lat)
        else $error("pause latency too long");
    property p_pause_at_once;
        $rose(paused_op_flag_r) |-> busy_r && !array_op_active_r;
    endproperty
    a_pause_at_once: assert property (p_pause_at_once)
        else $error("pause flag not set while busy");
    property p_pause_kind;
        $rose(paused_op_flag_r) |-> $past(busy_r) &&
            ($past(array_op_kind_r) inside {K_SECTOR, K_HALF, K_BLOCK, K_PROG});
    endproperty
    a_pause_kind: assert property (p_pause_kind)
        else $error("pause taken in wrong state");
    property p_resume_idle;
        $fell(paused_op_flag_r) |-> !$past(busy_r);
    endproperty
    a_resume_idle: assert property (p_resume_idle)
        else $error("resume taken while busy");
    property p_resume_busy;
        $fell(paused_op_flag_r) |-> ##[0:19] busy_r;
    endproperty
    a_resume_busy: assert property (p_resume_busy)
        else $error("busy late after resume");
    property p_active_busy;
        array_op_active_r |-> busy_r;
    endproperty
    a_active_busy: assert property (p_active_busy)
        else $error("array active without busy");
    property p_wel_end;
        $fell(busy_r) && !paused_op_flag_r |-> ##[0:1] !write_enable_latch_r;
    endproperty
    a_wel_end: assert property (p_wel_end)
        else $error("latch kept after completion");
    // kind trails busy and active by one cycle
    property p_wel_start;
        ($rose(busy_r) && !$past(paused_op_flag_r)) ##1
            !(array_op_kind_r inside {K_PROG, K_SECPROG})
            |-> $past(write_enable_latch_r, 2);
    endproperty
    a_wel_start: assert property (p_wel_start)
        else $error("erase started without latch");
    property p_chip_prot;
        $rose(array_op_active_r) ##1 (array_op_kind_r == K_CHIP) |->
            {protect_level_2, protect_level_1, protect_level_0} == PROT_NONE;
    endproperty
    a_chip_prot: assert property (p_chip_prot)
        else $error("array erase while protected");
    property p_paused_only_prog;
        paused_op_flag_r && array_op_active_r && $past(array_op_active_r)
            |-> array_op_kind_r == K_PROG;
    endproperty
    a_paused_only_prog: assert property (p_paused_only_prog)
        else $error("forbidden operation while paused");
    property p_pwrup;
        disable iff (1'b0)
        reset |=> !paused_op_flag_r && !busy_r && !write_enable_latch_r;
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("flags not cleared by reset");
    c_pause: cover property ($rose(paused_op_flag_r));
    c_resume: cover property ($fell(paused_op_flag_r));
    c_chip: cover property (array_op_active_r && array_op_kind_r == K_CHIP);
endmodule
bind ess_sequencer ess_sequencer_assertions ess_sequencer_assertions_i (
    .clk_sys(clk_sys), .reset(reset),
    .protect_level_2(protect_level_2), .protect_level_1(protect_level_1),
    .protect_level_0(protect_level_0), .busy_r(busy_r),
    .paused_op_flag_r(paused_op_flag_r),
    .write_enable_latch_r(write_enable_latch_r),
    .array_op_active_r(array_op_active_r),
    .array_op_kind_r(array_op_kind_r)
);
`default_nettype wire

/* ess_sequencer_test.sv */
/* self-checking bench for the erase / suspend sequencer.
   assumes the host model for frames; 1 us of run time is 100 cycles. */
`timescale 1ns/1ns
`default_nettype none
module ess_sequencer_test;
    import ess_pkg::*;
    logic clk_sys, reset, tbs, sup, prog_start, prog_secure;
    logic [2:0] prot;
    logic [23:0] prog_addr;
    wire link_clk, link_cs_n, link_data_in;
    wire busy, paused, write_enable_latch, ppb, active;
    ess_kind_e kind;
    wire [23:0] addr;
    int failures = 0;
    int n_checks = 0;
    ess_host_model ess_host_model_i (.link_clk(link_clk),
        .link_cs_n(link_cs_n), .link_data_in(link_data_in));
    ess_sequencer #(.LARGE_ERASE_TIME_US(4), .HALF_ERASE_TIME_US(4),
        .SECTOR_ERASE_TIME_US(1), .CHIP_ERASE_TIME_US(2),
        .PROG_TIME_US(1)) ess_sequencer_i (
        .clk_sys(clk_sys), .reset(reset), .link_clk(link_clk),
        .link_cs_n(link_cs_n), .link_data_in(link_data_in),
        .top_bottom_select(tbs), .small_unit_protect(sup),
        .protect_level_2(prot[2]), .protect_level_1(prot[1]),
        .protect_level_0(prot[0]), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_secure(prog_secure),
        .busy_r(busy), .paused_op_flag_r(paused),
        .write_enable_latch_r(write_enable_latch), .page_prog_block_r(ppb),
        .array_op_active_r(active), .array_op_kind_r(kind),
        .array_op_addr_r(addr));
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] a,
        input int n);
        @(negedge clk_sys);
        ess_host_model_i.send({op, a}, n);
        // judge outputs away from the edge that launches them
        @(negedge clk_sys);
    endtask
    task automatic wait_idle(input int lim, input string what);
        int c;
        c = 0;
        while (busy === 1'b1 && c < lim)
        begin
            @(negedge clk_sys);
            c++;
        end
        chk(what, 0, busy);
    endtask
    task automatic pulse(input logic [23:0] a, input logic s);
        @(posedge clk_sys);
        prog_addr <= a;
        prog_secure <= s;
        prog_start <= 1'b1;
        @(posedge clk_sys);
        prog_start <= 1'b0;
        // kind trails busy by one cycle
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic t_erase();
        for (int i = 0; i < 3; i++)
        begin
            cmd(OP_WREN, 24'h0, 8);
            chk("wel", 1, write_enable_latch);
            cmd(i == 0 ? OP_BLOCK64 : i == 1 ? OP_BLOCK32 : OP_SECTOR,
                24'h123456, 32);
            chk("busy", 1, busy);
            chk("kind", i == 0 ? K_BLOCK : i == 1 ? K_HALF : K_SECTOR,
                kind);
            chk("addr", 24'h123456, addr);
            wait_idle(500, "done");
            chk("wel", 0, write_enable_latch);
        end
        $display("test erase done");
    endtask
    task automatic t_refuse();
        cmd(OP_BLOCK64, 24'h010000, 32);
        chk("busy", 0, busy);
        cmd(OP_WREN, 24'h0, 8);
        cmd(OP_BLOCK64, 24'h010000, 31);
        chk("busy", 0, busy);
        cmd(OP_CHIP_A, 24'h0, 9);
        chk("busy", 0, busy);
        @(posedge clk_sys);
        prot <= 3'h1;
        cmd(OP_BLOCK64, 24'h3F0000, 32);
        chk("busy", 0, busy);
        cmd(OP_CHIP_B, 24'h0, 8);
        chk("busy", 0, busy);
        cmd(OP_PAUSE, 24'h0, 8);
        chk("paused", 0, paused);
        cmd(OP_RESUME, 24'h0, 8);
        chk("paused", 0, paused);
        chk("wel", 1, write_enable_latch);
        @(posedge clk_sys);
        prot <= PROT_NONE;
        $display("test refuse done");
    endtask
    task automatic t_chip();
        for (int i = 0; i < 2; i++)
        begin
            cmd(OP_WREN, 24'h0, 8);
            cmd(i ? OP_CHIP_B : OP_CHIP_A, 24'h0, 8);
            chk("kind", K_CHIP, kind);
            chk("busy", 1, busy);
            cmd(OP_PAUSE, 24'h0, 8);
            chk("paused", 0, paused);
            wait_idle(300, "done");
            chk("wel", 0, write_enable_latch);
        end
        $display("test chip done");
    endtask
    task automatic t_pause();
        cmd(OP_WREN, 24'h0, 8);
        cmd(OP_BLOCK64, 24'h200000, 32);
        cmd(OP_PAUSE, 24'h0, 8);
        chk("paused", 1, paused);
        chk("busy", 1, busy);
        wait_idle(2100, "pause");
        cmd(OP_BLOCK32, 24'h300000, 32);
        chk("active", 0, active);
        cmd(OP_SECTOR, 24'h200000, 32);
        chk("active", 0, active);
        pulse(24'h000100, 1'b0);
        chk("kind", K_PROG, kind);
        wait_idle(200, "prog");
        cmd(OP_RESUME, 24'h0, 8);
        chk("paused", 0, paused);
        chk("kind", K_BLOCK, kind);
        chk("addr", 24'h200000, addr);
        // a restarted erase would need some 270 more cycles
        wait_idle(220, "rest");
        $display("test pause done");
    endtask
    task automatic t_prog();
        pulse(24'h000200, 1'b0);
        cmd(OP_PAUSE, 24'h0, 8);
        chk("paused", 1, paused);
        chk("ppb", 1, ppb);
        wait_idle(2100, "pause");
        pulse(24'h001000, 1'b0);
        chk("busy", 0, busy);
        cmd(OP_WREN, 24'h0, 8);
        cmd(OP_BLOCK64, 24'h010000, 32);
        chk("active", 0, active);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk("paused", 0, paused);
        chk("ppb", 0, ppb);
        pulse(24'h000300, 1'b1);
        cmd(OP_PAUSE, 24'h0, 8);
        chk("paused", 0, paused);
        wait_idle(200, "secure");
        $display("test prog done");
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        reset = 1'b1;
        tbs = 1'b0;
        sup = 1'b0;
        prot = PROT_NONE;
        prog_start = 1'b0;
        prog_secure = 1'b0;
        prog_addr = 24'h0;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        t_erase();
        t_refuse();
        t_chip();
        t_pause();
        t_prog();
        conclude();
    end
    initial
    begin
        // the tests need some 10,500 cycles; allow well over three times that
        #400000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
